// ==== pcg_params.svh ====
// Operation
// - Serial port A clocked by low-speed clock
// - Bit 7 gates serial port D clock
// - Bit 5 gates UART port C clock
// - Bit 4 gives two-wire full system clock
// - Sync bit 2 clear halts all PWM time-bases
// - Enabled PWM keeps system clock regardless
// - Sync set starts all time-bases together
// - Second register bits clock encoder/capture/PWM
// - Clock registers writable only while unlocked
`ifndef PCG_PARAMS_SVH
`define PCG_PARAMS_SVH

// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define PCG_ADDR_W 4
`define PCG_OFF_ENABLE_0 4'h0
`define PCG_OFF_ENABLE_1 4'h4
`define PCG_OFF_UNLOCK 4'h8

// ----------------------------------------
// Field positions, first register and unlock register
// ----------------------------------------
`define PCG_BIT_SERIAL_A 8
`define PCG_BIT_SERIAL_D 7
`define PCG_BIT_UART_C 5
`define PCG_BIT_TWO_WIRE 4
`define PCG_BIT_TB_SYNC 2
`define PCG_EN0_WMASK 16'h01b4
`define PCG_UNLOCK_BIT 0

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define PCG_EN0_RESET 16'h0000
`define PCG_EN1_RESET 16'h0000
`define PCG_CLK_HZ 10000000
`define PCG_LSP_DIV 4
`define PCG_LSP_CNT_W 2

`endif

// ==== pcg_pkg.sv ====
`default_nettype none
package pcg_pkg;

	// Clock enables handed to the peripheral modules
	typedef struct packed {
		logic serial_port_a;
		logic serial_port_d;
		logic uart_port_c;
		logic two_wire;
		logic [1:0] encoder;
		logic [5:0] capture;
		logic [7:0] pwm;
		logic [7:0] pwm_timebase;
	} pcg_gate_t;

endpackage
`default_nettype wire

// ==== pcg_top.sv ====
// Register access over Wishbone and the placing of the registers were decided locally.
`include "pcg_params.svh"
`default_nettype none
module pcg_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [`PCG_ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output pcg_pkg::pcg_gate_t gate_o
);

	logic [15:0] peripheral_clock_enable_0;
	logic [15:0] peripheral_clock_enable_1;
	logic protected_write_unlock;
	logic [`PCG_LSP_CNT_W-1:0] lsp_cnt;
	logic low_speed_periph_clock;
	logic req;
	logic wr;
	logic clk_wr_ok;
	logic [15:0] lane_mask;
	logic [15:0] wdata;

	// ----------------------------------------
	// Overview
	// ----------------------------------------
	// Software owns two enable registers and a write key.
	// Low-speed ports get a one-cycle tick from the divider.
	// Full-rate modules get a level enable.
	// PWM time-bases also wait for the shared sync bit,
	// so setting it starts every enabled time-base on one edge.
	// Reserved bits of the first register never store; all sixteen of the second do.
	// All gates are registered, so they trail the register by one cycle.
	// The key itself is never locked, so software cannot shut itself out.

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------

	// New request only when ack not already given
	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr = req & wb_we_i;
	assign clk_wr_ok = wr & protected_write_unlock;
	assign lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign wdata = wb_dat_i[15:0];

	// ----------------------------------------
	// Write strobes
	// ----------------------------------------

	logic unlock_wr;
	logic en0_wr;
	logic en1_wr;

	// Key register is always open; it is the key itself
	assign unlock_wr = wr & (wb_adr_i == `PCG_OFF_UNLOCK) & wb_sel_i[0];
	// Clock registers take data only behind the key
	assign en0_wr = clk_wr_ok & (wb_adr_i == `PCG_OFF_ENABLE_0);
	assign en1_wr = clk_wr_ok & (wb_adr_i == `PCG_OFF_ENABLE_1);

	// Acknowledge every access one cycle after it is seen
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req;
		end
	end

	logic [31:0] next_rd_data;

	// Read mux; unmapped offsets and reserved bits read zero
	always_comb begin
		unique case (wb_adr_i)
			`PCG_OFF_ENABLE_0: next_rd_data = {16'h0000, peripheral_clock_enable_0};
			`PCG_OFF_ENABLE_1: next_rd_data = {16'h0000, peripheral_clock_enable_1};
			`PCG_OFF_UNLOCK: next_rd_data = {31'h0000_0000, protected_write_unlock};
			default: next_rd_data = 32'h0000_0000;
		endcase
	end

	// Read data is captured once and stands until the next read
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (req & ~wb_we_i) begin
			wb_dat_o <= next_rd_data;
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------

	// Protect latch: opens and closes the clock registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			protected_write_unlock <= 1'b0;
		end else if (unlock_wr) begin
			protected_write_unlock <= wb_dat_i[`PCG_UNLOCK_BIT];
		end
	end

	logic [15:0] next_enable_0;
	logic [15:0] next_enable_1;

	// Byte-lane merge; reserved bits of the first register never store
	always_comb begin
		next_enable_0 = (peripheral_clock_enable_0 & ~lane_mask) | (wdata & lane_mask & `PCG_EN0_WMASK);
		next_enable_1 = (peripheral_clock_enable_1 & ~lane_mask) | (wdata & lane_mask);
	end

	// First enable register; only documented bits store
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			peripheral_clock_enable_0 <= `PCG_EN0_RESET;
		end else if (en0_wr) begin
			peripheral_clock_enable_0 <= next_enable_0;
		end
	end

	// Second enable register, all sixteen bits writable
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			peripheral_clock_enable_1 <= `PCG_EN1_RESET;
		end else if (en1_wr) begin
			peripheral_clock_enable_1 <= next_enable_1;
		end
	end

	// ----------------------------------------
	// Low-speed clock enable divider
	// ----------------------------------------

	logic lsp_last;

	// Terminal count; the tick flop follows it by one cycle
	assign lsp_last = (lsp_cnt == `PCG_LSP_CNT_W'(`PCG_LSP_DIV - 1));

	// One-cycle pulse every PCG_LSP_DIV system cycles, free-running
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lsp_cnt <= '0;
			low_speed_periph_clock <= 1'b0;
		end else begin
			lsp_cnt <= lsp_cnt + `PCG_LSP_CNT_W'(1);
			low_speed_periph_clock <= lsp_last;
		end
	end

	// ----------------------------------------
	// Gated clock enables, low-speed ports
	// ----------------------------------------

	logic next_serial_port_a;
	logic next_serial_port_d;
	logic next_uart_port_c;

	// Low-speed ports see a tick only while enabled
	always_comb begin
		next_serial_port_a = peripheral_clock_enable_0[`PCG_BIT_SERIAL_A] & low_speed_periph_clock;
		next_serial_port_d = peripheral_clock_enable_0[`PCG_BIT_SERIAL_D] & low_speed_periph_clock;
		next_uart_port_c = peripheral_clock_enable_0[`PCG_BIT_UART_C] & low_speed_periph_clock;
	end

	// ----------------------------------------
	// Gated clock enables, full-rate modules
	// ----------------------------------------

	logic next_two_wire;
	logic [1:0] next_encoder;
	logic [5:0] next_capture;
	logic [7:0] next_pwm;

	// Full-rate modules follow their enable bit as a level
	always_comb begin
		next_two_wire = peripheral_clock_enable_0[`PCG_BIT_TWO_WIRE];
		next_encoder = peripheral_clock_enable_1[15:14];
		next_capture = peripheral_clock_enable_1[13:8];
		next_pwm = peripheral_clock_enable_1[7:0];
	end

	// ----------------------------------------
	// PWM time-base gating, one slice per channel
	// ----------------------------------------

	logic tb_run;
	logic [7:0] next_pwm_timebase;

	// Sync bit is shared, so every channel sees it in the same cycle
	assign tb_run = peripheral_clock_enable_0[`PCG_BIT_TB_SYNC];

	// A time-base runs only when its module is clocked and sync is set
	generate
		for (genvar ch = 0; ch < 8; ch++) begin : g_pwm_ch
			assign next_pwm_timebase[ch] = peripheral_clock_enable_1[ch] & tb_run;
		end
	endgenerate

	// ----------------------------------------
	// Output register
	// ----------------------------------------

	// Every gate leaves through one flop, so all time-bases start on one edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gate_o <= '0;
		end else begin
			gate_o.serial_port_a <= next_serial_port_a;
			gate_o.serial_port_d <= next_serial_port_d;
			gate_o.uart_port_c <= next_uart_port_c;
			gate_o.two_wire <= next_two_wire;
			gate_o.encoder <= next_encoder;
			gate_o.capture <= next_capture;
			gate_o.pwm <= next_pwm;
			gate_o.pwm_timebase <= next_pwm_timebase;
		end
	end

endmodule
`default_nettype wire

// ==== pcg_dummy_unused.sv ====
`default_nettype none
`default_nettype wire

// ==== pcg_chk.sv ====
`default_nettype none
module pcg_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire pcg_pkg::pcg_gate_t gate_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic unl;
	wire rd0 = wb_ack_o && !wb_we_i && wb_adr_i == 4'h0;
	wire wr0 = wb_ack_o && wb_we_i && wb_adr_i == 4'h0 && wb_sel_i[0];
	wire lsp = gate_o.serial_port_a | gate_o.serial_port_d | gate_o.uart_port_c;
	sequence s_gap;
		!lsp [*3];
	endsequence
	// Mirror of the write-unlock state
	always_ff @(posedge clk_i)
		if (rst_i) unl <= 1'b0;
		else if (wb_ack_o && wb_we_i && wb_adr_i == 4'h8 && wb_sel_i[0]) unl <= wb_dat_i[0];
	chk_ack_once: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack timing");
	chk_lsp_gap: assert property (lsp |=> s_gap)
		else $error("slow tick too close");
	chk_wr_apply: assert property (wr0 && unl |=> gate_o.two_wire == $past(wb_dat_i[4]))
		else $error("write not applied");
	chk_wr_locked: assert property (wr0 && !unl |=> $stable(gate_o.two_wire))
		else $error("locked write applied");
	chk_resv_zero: assert property (rd0 |-> (wb_dat_o[15:0] & 16'hfe4b) == 16'h0000)
		else $error("reserved bit set");
	chk_i2c_read: assert property (rd0 |-> wb_dat_o[4] == gate_o.two_wire)
		else $error("two-wire gate mismatch");
	chk_reg1_map: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 4'h4 |->
		wb_dat_o[15:0] == {gate_o.encoder, gate_o.capture, gate_o.pwm})
		else $error("second register gates");
	chk_tb_sync: assert property (rd0 |-> gate_o.pwm_timebase == (wb_dat_o[2] ? gate_o.pwm : 8'h00))
		else $error("time-base gate");
endmodule
bind pcg_top pcg_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
	.wb_dat_i, .wb_dat_o, .wb_ack_o, .gate_o);
`default_nettype wire

// ==== pcg_peer.sv ====
`default_nettype none
module pcg_peer (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire pcg_pkg::pcg_gate_t gate_i,
	output logic [7:0] ticks_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Serial port A counts the slow ticks it is fed
	always_ff @(posedge clk_i)
		if (rst_i) ticks_o <= 8'h00;
		else if (gate_i.serial_port_a) ticks_o <= ticks_o + 8'h01;
endmodule
`default_nettype wire

// ==== pcg_top_tb_top.sv ====
`default_nettype none
module pcg_top_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0, rst_i = 1'b1, req = 1'b0, we = 1'b0, ack;
	logic [3:0] adr = 4'h0, sel = 4'h0;
	logic [31:0] wdat = 32'h0, rdat, q;
	logic [7:0] t0, ticks, n_d;
	pcg_pkg::pcg_gate_t g;
	int bad_count = 0, cmp_count = 0, cyc_n = 0;
	initial forever #50 clk_i = ~clk_i;
	pcg_top u_dut (.clk_i, .rst_i, .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .gate_o(g));
	pcg_peer u_peer (.clk_i, .rst_i, .gate_i(g), .ticks_o(ticks));
	task test_done;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			bad_count++;
			$display("FAIL %s exp %h got %h", n, e, s);
		end
	endtask
	// One classic bus cycle, then one idle cycle
	task acc(input logic w, input logic [3:0] a, input logic [31:0] d);
		{req, we, adr, wdat, sel} <= {1'b1, w, a, d, 4'h3};
		do @(posedge clk_i); while (ack !== 1'b1);
		q = rdat;
		req <= 1'b0;
		@(posedge clk_i);
	endtask
	// Hang guard
	always @(posedge clk_i) begin
		cyc_n++;
		if (cyc_n > 2000) begin
			bad_count++;
			test_done;
		end
	end
	// Main sequence
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		acc(1'b0, 4'h0, 32'h0); chk("en0 reset", q, 32'h0);
		acc(1'b0, 4'h4, 32'h0); chk("en1 reset", q, 32'h0);
		acc(1'b1, 4'h0, 32'h1b4);
		acc(1'b0, 4'h0, 32'h0); chk("locked", q, 32'h0);
		acc(1'b1, 4'h8, 32'h1);
		acc(1'b1, 4'h4, 32'hc381);
		acc(1'b1, 4'h0, 32'h1b0);
		chk("pwm", g.pwm, 8'h81);
		chk("tb stop", g.pwm_timebase, 8'h00);
		acc(1'b1, 4'h0, 32'hffff);
		chk("tb start", g.pwm_timebase, 8'h81);
		chk("two wire", g.two_wire, 1'b1);
		acc(1'b0, 4'h0, 32'h0); chk("en0", q, 32'h1b4);
		acc(1'b0, 4'h4, 32'h0); chk("en1", q, 32'hc381);
		chk("gates1", {g.encoder, g.capture, g.pwm}, 16'hc381);
		t0 = ticks;
		n_d = 8'h00;
		repeat (40) begin
			@(posedge clk_i);
			n_d += {7'h00, g.serial_port_d & g.uart_port_c};
		end
		chk("slow ticks", ticks - t0, 8'h0a);
		chk("port d c ticks", n_d, 8'h0a);
		acc(1'b0, 4'hc, 32'h0); chk("unmapped", q, 32'h0);
		acc(1'b1, 4'h0, 32'h0); chk("off", {g.two_wire, g.pwm_timebase}, 9'h000);
		t0 = ticks;
		repeat (12) @(posedge clk_i);
		chk("a stopped", ticks - t0, 8'h00);
		test_done;
	end
endmodule
`default_nettype wire
